// ### rtl/hdlc_ctl_pkg.sv
/*
 * Shared constants and types of the HDLC / code controller control and status block:
 * register addresses, bit positions, byte values and the carrier structs.
 * Assumes one parallel control port with byte data, synchronous to the block clock.
 */
`default_nettype none

package hdlc_ctl_pkg;

   // ----------------------------------------------------------------
   // instances and register map
   // ----------------------------------------------------------------
   localparam int          NUM_FRAMERS    = 2;
   localparam logic [7:0]  ADDR_CONTROL_A = 8'h00;
   localparam logic [7:0]  ADDR_STATUS_A  = 8'h01;
   localparam logic [7:0]  ADDR_MASK_A    = 8'h02;
   localparam logic [7:0]  ADDR_CONTROL_B = 8'hA0;
   localparam logic [7:0]  ADDR_STATUS_B  = 8'hA1;
   localparam logic [7:0]  ADDR_MASK_B    = 8'hA2;
   localparam logic [7:0]  CONTROL_RESET  = 8'h00;
   localparam logic [7:0]  MASK_RESET     = 8'h00;
   localparam logic [7:0]  UNMAPPED_READ  = 8'h00;

   // ----------------------------------------------------------------
   // control register bit positions
   // ----------------------------------------------------------------
   localparam int CB_CODE_DETECTOR_RESET = 7;
   localparam int CB_RX_CONTROLLER_RESET = 6;
   localparam int CB_TX_IDLE_SELECT      = 5;
   localparam int CB_TX_PATH_RESET       = 4;
   localparam int CB_TX_ABORT            = 3;
   localparam int CB_TX_LAST_BYTE_MARK   = 2;
   localparam int CB_TX_STUFFER_DEFEAT   = 1;
   localparam int CB_TX_FCS_DEFEAT       = 0;

   // ----------------------------------------------------------------
   // status register bit positions
   // ----------------------------------------------------------------
   localparam int SB_RX_CODE_CHANGE      = 7;
   localparam int SB_RX_PACKET_END       = 6;
   localparam int SB_RX_PACKET_START     = 5;
   localparam int SB_RX_FIFO_HALF_FULL   = 4;
   localparam int SB_RX_FIFO_NOT_EMPTY   = 3;
   localparam int SB_TX_FIFO_HALF_EMPTY  = 2;
   localparam int SB_TX_FIFO_NOT_FULL    = 1;
   localparam int SB_TX_MESSAGE_DONE     = 0;
   localparam logic [7:0] LATCHED_BITS   = 8'hE1;

   // ----------------------------------------------------------------
   // transmit fill bytes and fifo geometry
   // ----------------------------------------------------------------
   localparam logic [7:0] ABORT_BYTE     = 8'hFE;
   localparam logic [7:0] FLAG_BYTE      = 8'h7E;
   localparam logic [7:0] IDLE_BYTE      = 8'hFF;
   localparam int         FIFO_DEPTH_DEF = 64;
   localparam int         CNT_W          = 7;

   typedef enum logic [2:0] {
      FILL_OFF   = 3'b001,
      FILL_ABORT = 3'b010,
      FILL_IDLE  = 3'b100
   } fill_state_t;

   // datapath to control block, one per framer
   typedef struct packed {
      logic             code_detected;
      logic             rx_packet_start;
      logic             rx_packet_end;
      logic [CNT_W-1:0] rx_fifo_count;
      logic [CNT_W-1:0] tx_fifo_count;
      logic             tx_fifo_write;
      logic             tx_last_byte_sent;
      logic             tx_fill_taken;
   } dp_in_t;

   // control block to datapath, one per framer
   typedef struct packed {
      logic       code_detector_reset;
      logic       rx_controller_reset;
      logic       tx_path_reset;
      logic       tx_fifo_flush;
      logic       tx_stuffer_enable;
      logic       tx_fcs_enable;
      logic       tx_fill_active;
      logic [7:0] tx_fill_byte;
   } dp_out_t;

   typedef struct packed {
      logic [7:0]  control;
      logic [7:0]  mask;
      logic [7:0]  latched;
      logic        code_prev;
      fill_state_t fill;
      dp_out_t     out;
   } framer_t;

   typedef struct packed {
      framer_t [NUM_FRAMERS-1:0] fr;
      logic [7:0]                rdata;
      logic                      int_n;
   } state_t;

endpackage

`default_nettype wire

// ### rtl/hdlc_ctl.sv
/*
 * Control, status and event-mask registers of both HDLC / code controllers,
 * plus the transmit abort and fill-byte sequencer.
 * Assumes the framer datapath reports its events as one-cycle pulses and its fifo
 * levels as counts, all synchronous to clock; host strobes are one cycle wide.
 */
`timescale 1ns/1ps
`default_nettype none

module hdlc_ctl
   import hdlc_ctl_pkg::*;
#(
   parameter int FIFO_DEPTH = FIFO_DEPTH_DEF
) (
   // clock and reset
   input  wire logic                               clock,
   input  wire logic                               reset_n,
   // parallel control port
   input  wire logic [7:0]                         addr,
   input  wire logic                               wr_en,
   input  wire logic                               rd_en,
   input  wire logic [7:0]                         wdata,
   output logic [7:0]                              rdata,
   // interrupt
   output logic                                    int_n,
   // framer datapaths
   input  wire hdlc_ctl_pkg::dp_in_t  [hdlc_ctl_pkg::NUM_FRAMERS-1:0] dp_in,
   output hdlc_ctl_pkg::dp_out_t      [hdlc_ctl_pkg::NUM_FRAMERS-1:0] dp_out
);
   import hdlc_ctl_pkg::*;

   // ----------------------------------------------------------------
   // constants derived from the fifo depth
   // ----------------------------------------------------------------
   localparam logic [CNT_W-1:0] HALF_LEVEL = CNT_W'(FIFO_DEPTH / 2);
   localparam logic [CNT_W-1:0] FULL_LEVEL = CNT_W'(FIFO_DEPTH);

   state_t s_q;
   state_t s_d;

   // ----------------------------------------------------------------
   // address decode helpers
   // ----------------------------------------------------------------
   function automatic logic [7:0] control_addr(input int idx);
      control_addr = (idx == 0) ? ADDR_CONTROL_A : ADDR_CONTROL_B;
   endfunction

   function automatic logic [7:0] status_addr(input int idx);
      status_addr = (idx == 0) ? ADDR_STATUS_A : ADDR_STATUS_B;
   endfunction

   function automatic logic [7:0] mask_addr(input int idx);
      mask_addr = (idx == 0) ? ADDR_MASK_A : ADDR_MASK_B;
   endfunction

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      logic [7:0] ctrl_old;
      logic [7:0] ctrl_new;
      logic [7:0] rising;
      logic [7:0] live;
      logic [7:0] sets;
      logic [7:0] status;
      logic       any_irq;
      logic       mapped;
      logic [7:0] rd_val;
      ctrl_old = '0;
      ctrl_new = '0;
      rising   = '0;
      live     = '0;
      sets     = '0;
      status   = '0;
      any_irq  = 1'b0;
      mapped   = 1'b0;
      rd_val   = UNMAPPED_READ;
      s_d      = s_q;

      for (int i = 0; i < NUM_FRAMERS; i++) begin
         // control register: hardware clear of the last-byte mark, then host write
         ctrl_old = s_q.fr[i].control;
         ctrl_new = ctrl_old;
         if (dp_in[i].tx_last_byte_sent) begin
            ctrl_new[CB_TX_LAST_BYTE_MARK] = 1'b0;
         end
         // a host write in the same cycle wins, so a fresh mark is never lost
         if (wr_en && addr == control_addr(i)) begin
            ctrl_new = wdata;
         end
         s_d.fr[i].control = ctrl_new;
         rising = ~ctrl_old & ctrl_new;

         // edge-triggered resets: a level held high does nothing further
         s_d.fr[i].out.code_detector_reset = rising[CB_CODE_DETECTOR_RESET];
         s_d.fr[i].out.rx_controller_reset = rising[CB_RX_CONTROLLER_RESET];
         s_d.fr[i].out.tx_path_reset       = rising[CB_TX_PATH_RESET];
         s_d.fr[i].out.tx_fifo_flush       = rising[CB_TX_ABORT];
         s_d.fr[i].out.tx_stuffer_enable   = ~ctrl_new[CB_TX_STUFFER_DEFEAT];
         s_d.fr[i].out.tx_fcs_enable       = ~ctrl_new[CB_TX_FCS_DEFEAT];

         // abort and fill sequencer
         unique case (s_q.fr[i].fill)
            FILL_OFF: begin
               if (rising[CB_TX_ABORT]) begin
                  s_d.fr[i].fill = FILL_ABORT;
               end
            end
            FILL_ABORT: begin
               if (dp_in[i].tx_fill_taken) begin
                  s_d.fr[i].fill = FILL_IDLE;
               end
            end
            FILL_IDLE: begin
               if (rising[CB_TX_ABORT]) begin
                  s_d.fr[i].fill = FILL_ABORT;
               end else if (dp_in[i].tx_fifo_write) begin
                  s_d.fr[i].fill = FILL_OFF;
               end
            end
            default: begin
               s_d.fr[i].fill = FILL_OFF;
            end
         endcase
         // a transmit path reset drops any abort in progress, unless the abort bit rises in the same cycle
         if (rising[CB_TX_PATH_RESET] && !rising[CB_TX_ABORT]) begin
            s_d.fr[i].fill = FILL_OFF;
         end
         s_d.fr[i].out.tx_fill_active = (s_d.fr[i].fill != FILL_OFF);
         if (s_d.fr[i].fill == FILL_ABORT) begin
            s_d.fr[i].out.tx_fill_byte = ABORT_BYTE;
         end else if (ctrl_new[CB_TX_IDLE_SELECT]) begin
            s_d.fr[i].out.tx_fill_byte = IDLE_BYTE;
         end else begin
            s_d.fr[i].out.tx_fill_byte = FLAG_BYTE;
         end

         // event mask register
         if (wr_en && addr == mask_addr(i)) begin
            s_d.fr[i].mask = wdata;
         end

         // live status levels
         live = '0;
         live[SB_RX_FIFO_HALF_FULL]  = dp_in[i].rx_fifo_count > HALF_LEVEL;
         live[SB_RX_FIFO_NOT_EMPTY]  = dp_in[i].rx_fifo_count != '0;
         live[SB_TX_FIFO_HALF_EMPTY] = dp_in[i].tx_fifo_count < HALF_LEVEL;
         live[SB_TX_FIFO_NOT_FULL]   = dp_in[i].tx_fifo_count < FULL_LEVEL;

         // latched events
         s_d.fr[i].code_prev = dp_in[i].code_detected;
         sets = '0;
         sets[SB_RX_CODE_CHANGE]  = dp_in[i].code_detected ^ s_q.fr[i].code_prev;
         sets[SB_RX_PACKET_END]   = dp_in[i].rx_packet_end;
         sets[SB_RX_PACKET_START] = dp_in[i].rx_packet_start;
         sets[SB_TX_MESSAGE_DONE] = dp_in[i].tx_last_byte_sent;

         status = (s_q.fr[i].latched & LATCHED_BITS) | live;
         if (rd_en && addr == status_addr(i)) begin
            // an event landing in the read cycle survives the clear
            s_d.fr[i].latched = sets & LATCHED_BITS;
         end else begin
            s_d.fr[i].latched = (s_q.fr[i].latched | sets) & LATCHED_BITS;
         end

         // interrupt from what software would see next cycle
         if ((((s_d.fr[i].latched | live) & s_d.fr[i].mask) != '0)) begin
            any_irq = 1'b1;
         end

         // read mux
         if (addr == control_addr(i)) begin
            mapped = 1'b1;
            rd_val = s_q.fr[i].control;
         end else if (addr == status_addr(i)) begin
            mapped = 1'b1;
            rd_val = status;
         end else if (addr == mask_addr(i)) begin
            mapped = 1'b1;
            rd_val = s_q.fr[i].mask;
         end
      end

      if (rd_en) begin
         s_d.rdata = mapped ? rd_val : UNMAPPED_READ;
      end
      s_d.int_n = ~any_irq;
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         for (int i = 0; i < NUM_FRAMERS; i++) begin
            s_q.fr[i].control <= CONTROL_RESET;
            s_q.fr[i].mask    <= MASK_RESET;
            s_q.fr[i].latched <= '0;
            s_q.fr[i].code_prev <= 1'b0;
            s_q.fr[i].fill    <= FILL_OFF;
            s_q.fr[i].out     <= '0;
         end
         s_q.rdata <= UNMAPPED_READ;
         s_q.int_n <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   // ----------------------------------------------------------------
   // outputs straight from the state register
   // ----------------------------------------------------------------
   assign rdata = s_q.rdata;
   assign int_n = s_q.int_n;
   always_comb begin
      for (int i = 0; i < NUM_FRAMERS; i++) begin
         dp_out[i] = s_q.fr[i].out;
      end
   end

endmodule

`default_nettype wire

// ### dv/hdlc_ctl_checker.sv
/* assertions on the control block ports: edge pulses, fill sequence, levels, irq.
   assumes the bind below attaches it to every hdlc_ctl instance. */
`timescale 1ns/1ps
`default_nettype none
module hdlc_ctl_checker
   import hdlc_ctl_pkg::*;
#(
   parameter int FIFO_DEPTH = FIFO_DEPTH_DEF
) (
   input wire logic                                         clock,
   input wire logic                                         reset_n,
   input wire logic [7:0]                                   addr,
   input wire logic                                         wr_en,
   input wire logic                                         rd_en,
   input wire logic [7:0]                                   wdata,
   input wire logic [7:0]                                   rdata,
   input wire logic                                         int_n,
   input wire hdlc_ctl_pkg::dp_in_t  [NUM_FRAMERS-1:0]       dp_in,
   input wire hdlc_ctl_pkg::dp_out_t [NUM_FRAMERS-1:0]       dp_out
);
   // ----------------------------------------------------------------
   // shadow of host writes: framer a control, both framers' masks
   // ----------------------------------------------------------------
   logic [7:0] ctl_q;
   logic [7:0] rise_q;
   logic [7:0] ma_q;
   logic [7:0] mb_q;
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         ctl_q  <= CONTROL_RESET;
         rise_q <= 8'h00;
         ma_q   <= MASK_RESET;
         mb_q   <= MASK_RESET;
      end else begin
         rise_q <= (wr_en && addr == ADDR_CONTROL_A) ? (wdata & ~ctl_q) : 8'h00;
         if (wr_en && addr == ADDR_CONTROL_A) ctl_q <= wdata;
         if (wr_en && addr == ADDR_MASK_A) ma_q <= wdata;
         if (wr_en && addr == ADDR_MASK_B) mb_q <= wdata;
      end
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (!reset_n);
   a_code_reset_edge: assert property (dp_out[0].code_detector_reset == rise_q[7])
      else $error("code detector reset pulse wrong");
   a_rx_reset_edge: assert property (dp_out[0].rx_controller_reset == rise_q[6])
      else $error("rx controller reset pulse wrong");
   a_tx_reset_edge: assert property (dp_out[0].tx_path_reset == rise_q[4])
      else $error("tx path reset pulse wrong");
   a_abort_start: assert property (rise_q[3] |-> dp_out[0].tx_fifo_flush && dp_out[0].tx_fill_active
      && dp_out[0].tx_fill_byte == ABORT_BYTE ##1 !dp_out[0].tx_fifo_flush) else $error("abort start wrong");
   a_fill_after_abort: assert property (dp_out[0].tx_fill_active && dp_out[0].tx_fill_byte == ABORT_BYTE
      && dp_in[0].tx_fill_taken && !wr_en |=> dp_out[0].tx_fill_byte == (ctl_q[5] ? IDLE_BYTE : FLAG_BYTE))
      else $error("fill byte after abort wrong");
   a_fill_release: assert property (dp_out[0].tx_fill_active && dp_in[0].tx_fifo_write && !wr_en
      |=> !dp_out[0].tx_fill_active) else $error("fill not released by fifo write");
   a_stuffer_level: assert property ($past(reset_n) |-> dp_out[0].tx_stuffer_enable == !ctl_q[1])
      else $error("stuffer enable wrong");
   a_irq_quiet: assert property (!wr_en && ma_q == 8'h00 && mb_q == 8'h00 |=> int_n)
      else $error("irq while all masked");
   a_done_irq: assert property (ma_q[SB_TX_MESSAGE_DONE] && dp_in[0].tx_last_byte_sent |=> !int_n)
      else $error("message done irq missing");
   a_rdata_holds: assert property (!rd_en |=> $stable(rdata))
      else $error("read data moved without read");
endmodule
bind hdlc_ctl hdlc_ctl_checker #(.FIFO_DEPTH(FIFO_DEPTH)) u_chk (.clock(clock), .reset_n(reset_n),
   .addr(addr), .wr_en(wr_en), .rd_en(rd_en), .wdata(wdata), .rdata(rdata), .int_n(int_n),
   .dp_in(dp_in), .dp_out(dp_out));
`default_nettype wire

// ### dv/framer_dp_model.sv
/* behavioural framer datapath: passes bench events, dumps the fifo on flush,
   takes a fill byte every fourth cycle. assumes one instance per framer. */
`timescale 1ns/1ps
`default_nettype none
module framer_dp_model
   import hdlc_ctl_pkg::*;
(
   // clock and reset
   input  wire logic                  clock,
   input  wire logic                  reset_n,
   // bench events and block outputs
   input  wire hdlc_ctl_pkg::dp_in_t  ev,
   input  wire hdlc_ctl_pkg::dp_out_t ctl,
   // to the block
   output var  hdlc_ctl_pkg::dp_in_t  dp
);
   logic [1:0] pace_q;
   logic       flushed_q;
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         pace_q    <= 2'b00;
         flushed_q <= 1'b0;
      end else begin
         // slow link, so each fill byte stands several cycles
         pace_q <= ctl.tx_fill_active ? pace_q + 2'd1 : 2'b00;
         if (ctl.tx_fifo_flush) flushed_q <= 1'b1;
         else if (ev.tx_fifo_write) flushed_q <= 1'b0;
      end
   end
   always_comb begin
      dp = ev;
      dp.tx_fill_taken = ctl.tx_fill_active && pace_q == 2'b11;
      if (flushed_q) dp.tx_fifo_count = '0;
   end
endmodule
`default_nettype wire

// ### dv/hdlc_boc_control_status_test.sv
/* self-checking bench of hdlc_ctl: host port tasks, two datapath models.
   assumes the checker is bound in by its own file. */
`timescale 1ns/1ps
`default_nettype none
module hdlc_boc_control_status_test;
   import hdlc_ctl_pkg::*;
   localparam int FD = 64;
   logic clock = 1'b0, reset_n = 1'b0, wr_en = 1'b0, rd_en = 1'b0, int_n;
   logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, v, ca;
   logic [6:0] rcn [2] = '{7'h00, 7'h00}, tcn [2] = '{7'h00, 7'h00};
   logic [6:0] bnd [5] = '{7'h00, 7'h01, 7'h20, 7'h21, 7'h40};
   int cb [4] = '{7, 6, 4, 3};
   int n_mismatch = 0, samples_checked = 0, i;
   dp_in_t [1:0] ev = '0;
   dp_in_t p;
   wire dp_in_t [1:0] dpi;
   dp_out_t [1:0] dpo;
   always #10 clock = ~clock;
   hdlc_ctl #(.FIFO_DEPTH(FD)) dut (.clock(clock), .reset_n(reset_n), .addr(addr), .wr_en(wr_en),
      .rd_en(rd_en), .wdata(wdata), .rdata(rdata), .int_n(int_n), .dp_in(dpi), .dp_out(dpo));
   for (genvar g = 0; g < 2; g++) begin : g_dp
      framer_dp_model u_dp (.clock(clock), .reset_n(reset_n), .ev(ev[g]), .ctl(dpo[g]), .dp(dpi[g]));
   end
   // ----------------------------------------------------------------
   // host port and checking tasks
   // ----------------------------------------------------------------
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      samples_checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      wr_en <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clock);
      wr_en <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clock);
      rd_en <= 1'b1;
      addr <= a;
      @(posedge clock);
      rd_en <= 1'b0;
      #1 d = rdata;
   endtask
   // pulse bits of p on both framers for one cycle
   task automatic pulse();
      @(posedge clock);
      ev[0] <= ev[0] | p;
      ev[1] <= ev[1] | p;
      @(posedge clock);
      ev[0] <= ev[0] & ~p;
      ev[1] <= ev[1] & ~p;
      #1;
   endtask
   task automatic wait_byte(input logic [7:0] b);
      for (int k = 0; k < 20 && dpo[0].tx_fill_byte !== b; k++) begin
         @(posedge clock);
         #1;
      end
      chk(dpo[0].tx_fill_byte, b, "fill byte");
      // a fill byte that never shows ends the run here
      if (dpo[0].tx_fill_byte !== b) begin
         end_of_test();
      end
   endtask
   function automatic logic pick(input dp_out_t o, input int b);
      case (b)
         7: pick = o.code_detector_reset;
         6: pick = o.rx_controller_reset;
         4: pick = o.tx_path_reset;
         default: pick = o.tx_fifo_flush;
      endcase
   endfunction
   function automatic logic [7:0] live(input logic [6:0] rc, input logic [6:0] tc);
      live = 8'h00;
      live[SB_RX_FIFO_HALF_FULL] = rc > FD / 2;
      live[SB_RX_FIFO_NOT_EMPTY] = rc != 0;
      live[SB_TX_FIFO_HALF_EMPTY] = tc < FD / 2;
      live[SB_TX_FIFO_NOT_FULL] = tc < FD;
   endfunction
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      void'($urandom(9807));
      repeat (4) @(posedge clock);
      reset_n <= 1'b1;
      foreach (cb[j]) begin
         rd(j < 2 ? (j ? ADDR_CONTROL_B : ADDR_CONTROL_A) : (j == 2 ? ADDR_MASK_A : ADDR_MASK_B), v);
         chk(v, 8'h00, "reset value");
      end
      rd(8'h5C, v);
      chk(v, UNMAPPED_READ, "unmapped");
      $display("test reset values done");
      foreach (cb[j]) begin
         for (int f = 0; f < 2; f++) begin
            ca = f ? ADDR_CONTROL_B : ADDR_CONTROL_A;
            wr(ca, 8'h00);
            wr(ca, 8'h01 << cb[j]);
            chk({7'h00, pick(dpo[f], cb[j])}, 8'h01, "edge pulse");
            wr(ca, 8'h01 << cb[j]);
            chk({7'h00, pick(dpo[f], cb[j])}, 8'h00, "held bit");
            wr(ca, 8'h00);
         end
      end
      $display("test control edges done");
      wr(ADDR_CONTROL_A, 8'h08);
      chk(dpo[0].tx_fill_byte, ABORT_BYTE, "abort byte");
      wait_byte(FLAG_BYTE);
      wr(ADDR_CONTROL_A, 8'h28);
      wait_byte(IDLE_BYTE);
      p = '0;
      p.tx_fifo_write = 1'b1;
      pulse();
      chk({7'h00, dpo[0].tx_fill_active}, 8'h00, "fill ended");
      $display("test abort done");
      for (int k = 0; k < 12; k++) begin
         i = k % 2;
         rcn[i] = (k < 5) ? bnd[k] : 7'($urandom_range(FD));
         tcn[i] = (k < 5) ? bnd[4 - k] : 7'($urandom_range(FD));
         @(posedge clock);
         ev[i].rx_fifo_count <= rcn[i];
         ev[i].tx_fifo_count <= tcn[i];
         rd(i ? ADDR_STATUS_B : ADDR_STATUS_A, v);
         chk(v, live(rcn[i], tcn[i]), "live status");
      end
      $display("test live status done");
      wr(ADDR_MASK_B, 8'h20);
      rd(ADDR_MASK_B, v);
      chk(v, 8'h20, "mask readback");
      p = '0;
      p.code_detected = 1'b1;
      p.rx_packet_start = 1'b1;
      p.rx_packet_end = 1'b1;
      p.tx_last_byte_sent = 1'b1;
      pulse();
      @(posedge clock);
      #1;
      chk({7'h00, int_n}, 8'h00, "irq low");
      rd(ADDR_STATUS_B, v);
      chk(v, LATCHED_BITS | live(rcn[1], tcn[1]), "events");
      @(posedge clock);
      #1;
      chk({7'h00, int_n}, 8'h01, "irq cleared");
      rd(ADDR_STATUS_B, v);
      chk(v, live(rcn[1], tcn[1]), "cleared on read");
      wr(ADDR_STATUS_B, 8'hFF);
      rd(ADDR_STATUS_B, v);
      chk(v, live(rcn[1], tcn[1]), "status write ignored");
      wr(ADDR_MASK_B, 8'h00);
      rd(ADDR_STATUS_A, v);
      $display("test events done");
      wr(ADDR_MASK_A, 8'h01);
      wr(ADDR_CONTROL_A, 8'h07);
      chk({6'h00, dpo[0].tx_stuffer_enable, dpo[0].tx_fcs_enable}, 8'h00, "defeats");
      p = '0;
      p.tx_last_byte_sent = 1'b1;
      pulse();
      rd(ADDR_CONTROL_A, v);
      chk(v, 8'h03, "mark cleared");
      wr(ADDR_CONTROL_A, 8'h00);
      chk({6'h00, dpo[0].tx_stuffer_enable, dpo[0].tx_fcs_enable}, 8'h03, "enables");
      $display("test last byte done");
      end_of_test();
   end
endmodule
`default_nettype wire
